// ===== inc/eecp_pkg.sv
// Purpose: constants and types of the eeprom control and protect block
// Assumes: 16-bit classic wishbone, byte addresses, even byte on [15:8]
// Notes: one register per byte lane inside the control block
package eecp_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [15:0] EECP_MCFG_ADR = 16'h00F0;
   localparam logic [15:0] EECP_BPROT_ADR = 16'h00F1;
   localparam logic [15:0] EECP_TEST_ADR = 16'h00F2;
   localparam logic [15:0] EECP_PCTL_ADR = 16'h00F3;
   localparam logic [15:0] EECP_INIT_ADR = 16'h0012;
   // array window and protect block starts
   localparam logic [15:0] EECP_ARR_LO = 16'h0D00;
   localparam logic [15:0] EECP_ARR_HI = 16'h0FFF;
   localparam logic [15:0] EECP_BLK3_LO = 16'h0E00;
   localparam logic [15:0] EECP_BLK2_LO = 16'h0F00;
   localparam logic [15:0] EECP_BLK1_LO = 16'h0F80;
   localparam logic [15:0] EECP_BLK0_LO = 16'h0FC0;
   localparam logic [8:0] EECP_LAST_IDX = 9'h17F;
   localparam int EECP_WORDS = 384;
   // ****************************************
   // field positions
   // ****************************************
   localparam int EECP_MC_WCH = 0;
   localparam int EECP_MC_LOCK = 1;
   localparam int EECP_MC_RC = 2;
   localparam int EECP_TS_MON = 0;
   localparam int EECP_TS_RDIS = 1;
   localparam int EECP_TS_PDIS = 2;
   localparam int EECP_TS_MARGIN_TEST = 3;
   localparam int EECP_TS_EVEN = 5;
   localparam int EECP_TS_ODD = 6;
   localparam int EECP_PC_PGM = 0;
   localparam int EECP_PC_LAT = 1;
   localparam int EECP_PC_ERASE = 2;
   localparam int EECP_PC_ROW = 3;
   localparam int EECP_PC_BYTE = 4;
   localparam int EECP_PC_BULK_ERASE_PROTECT = 7;
   localparam int EECP_IN_REE = 0;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] EECP_MCFG_RST = 8'h00;
   localparam logic [4:0] EECP_BPROT_RST = 5'h1F;
   localparam logic [7:0] EECP_TEST_RST = 8'h00;
   localparam logic [7:0] EECP_PCTL_RST = 8'h00;
   localparam logic EECP_REE_RST = 1'b1;
   // ****************************************
   // program and erase engine states
   // ****************************************
   typedef enum logic [1:0]
   {
      EECP_IDLE = 2'b00,
      EECP_RUN = 2'b01,
      EECP_DONE = 2'b10
   } eecp_state_e;
endpackage : eecp_pkg

// ===== rtl/eecp_ctrl.sv
// Purpose: control, protection and array of a 768-byte eeprom
// Assumes: classic wishbone slave, 16-bit data, one clock at 10 MHz
// Notes: the array itself is modelled as flops with no reset
`timescale 1ns/1ns
`default_nettype none
module eecp_ctrl
   import eecp_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [1:0] wb_sel_i,
   input wire logic [15:0] wb_dat_i,
   output logic [15:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic special_mode_n,
   input wire logic wait_mode,
   input wire logic stop_mode,
   output logic pump_on,
   output logic pump_clk_sel,
   output logic rc_osc_en,
   output logic module_clk_en,
   output logic margin_test,
   output logic pump_ramp_en,
   output logic pump_monitor_out,
   output logic program_voltage_apply
);
   // ****************************************
   // state
   // ****************************************
   logic [7:0] mcfg_r;
   logic lock_used_r;
   logic [4:0] bprot_r;
   logic [7:0] test_r;
   logic [7:0] pctl_r;
   logic ree_r;
   logic ack_r;
   logic [15:0] dat_r;
   logic [8:0] lat_idx_r;
   logic [15:0] lat_dat_r;
   logic [1:0] lat_sel_r;
   logic lat_valid_r;
   eecp_state_e st_r;
   eecp_state_e st_nxt;
   logic [8:0] cur_r;
   logic [8:0] cur_nxt;
   logic [8:0] last_r;
   logic [8:0] last_nxt;
   logic [15:0] mem [0:EECP_WORDS-1];

   // ****************************************
   // bus decode
   // ****************************************
   wire req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire wr = req & wb_we_i;
   wire rd = req & ~wb_we_i;
   wire [15:0] word_adr = {wb_adr_i[15:1], 1'b0};
   wire in_arr = wb_adr_i >= EECP_ARR_LO && wb_adr_i <= EECP_ARR_HI;
   wire [15:0] arr_off = wb_adr_i - EECP_ARR_LO;
   wire [8:0] arr_idx = arr_off[9:1];
   wire hit_mc = word_adr == EECP_MCFG_ADR;
   wire hit_ts = word_adr == EECP_TEST_ADR;
   wire hit_in = word_adr == EECP_INIT_ADR;
   wire wr_mc = wr & hit_mc & wb_sel_i[1];
   wire wr_bp = wr & hit_mc & wb_sel_i[0];
   wire wr_ts = wr & hit_ts & wb_sel_i[1];
   wire wr_pc = wr & hit_ts & wb_sel_i[0];
   wire wr_in = wr & hit_in & wb_sel_i[1];
   wire [7:0] wd_hi = wb_dat_i[15:8];
   wire [7:0] wd_lo = wb_dat_i[7:0];

   // control bit views
   wire wch = mcfg_r[EECP_MC_WCH];
   wire lock = mcfg_r[EECP_MC_LOCK];
   wire rc_sel = mcfg_r[EECP_MC_RC];
   wire pgm = pctl_r[EECP_PC_PGM];
   wire lat = pctl_r[EECP_PC_LAT];
   wire erase = pctl_r[EECP_PC_ERASE];
   wire row = pctl_r[EECP_PC_ROW];
   wire bsel = pctl_r[EECP_PC_BYTE];
   wire bulk_erase_protect = pctl_r[EECP_PC_BULK_ERASE_PROTECT];
   wire odd = test_r[EECP_TS_ODD];
   wire even = test_r[EECP_TS_EVEN];

   // ****************************************
   // clocking, pump and stop control
   // ****************************************
   assign module_clk_en = ~(wait_mode & wch);
   assign pump_clk_sel = rc_sel;
   assign rc_osc_en = rc_sel & ~stop_mode;
   wire pump_act = pgm & ~stop_mode & module_clk_en;
   assign pump_on = pump_act & ~test_r[EECP_TS_PDIS];
   assign pump_ramp_en = pump_on & ~test_r[EECP_TS_RDIS];
   assign margin_test = test_r[EECP_TS_MARGIN_TEST] & pgm;
   assign pump_monitor_out = test_r[EECP_TS_MON];
   assign program_voltage_apply = pgm;

   // ****************************************
   // operation selection
   // ****************************************
   wire tst_rows = odd | even;
   wire bulk_op = tst_rows | (erase & ~bsel & ~row);
   wire row_op = ~tst_rows & erase & ~bsel & row;
   wire [15:0] cur_adr = EECP_ARR_LO + {6'h00, cur_r, 1'b0};
   // protect block of the word in work
   wire cur_prot = (cur_adr < EECP_BLK3_LO) ? bprot_r[4] :
      (cur_adr < EECP_BLK2_LO) ? bprot_r[3] :
      (cur_adr < EECP_BLK1_LO) ? bprot_r[2] :
      (cur_adr < EECP_BLK0_LO) ? bprot_r[1] : bprot_r[0];
   wire row_ok = ~tst_rows | (odd & cur_r[4]) | (even & ~cur_r[4]);
   wire blk_bulk = bulk_erase_protect & (bulk_op | row_op) & erase;
   wire step = (st_r == EECP_RUN) & pump_on;
   wire do_wr = step & ~cur_prot & ~blk_bulk & row_ok;
   wire [1:0] wmask = (bulk_op | row_op) ? 2'b11 : lat_sel_r;
   wire [15:0] wval = erase ? 16'hFFFF : lat_dat_r;

   // engine next state
   always_comb
   begin
      st_nxt = st_r;
      cur_nxt = cur_r;
      last_nxt = last_r;
      case (st_r)
         EECP_IDLE:
         begin
            if (pgm && lat_valid_r)
            begin
               st_nxt = EECP_RUN;
               if (bulk_op)
               begin
                  cur_nxt = 9'h000;
                  last_nxt = EECP_LAST_IDX;
               end
               else if (row_op)
               begin
                  cur_nxt = {lat_idx_r[8:4], 4'h0};
                  last_nxt = {lat_idx_r[8:4], 4'hF};
               end
               else
               begin
                  cur_nxt = lat_idx_r;
                  last_nxt = lat_idx_r;
               end
            end
            else if (pgm)
               st_nxt = EECP_DONE;
         end
         EECP_RUN:
         begin
            if (!pgm)
               st_nxt = EECP_IDLE;
            else if (step && cur_r == last_r)
               st_nxt = EECP_DONE;
            else if (step)
               cur_nxt = cur_r + 9'h001;
         end
         EECP_DONE:
         begin
            if (!pgm)
               st_nxt = EECP_IDLE;
         end
         default:
            st_nxt = EECP_IDLE;
      endcase
   end

   // engine registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= EECP_IDLE;
         cur_r <= 9'h000;
         last_r <= 9'h000;
      end
      else
      begin
         st_r <= st_nxt;
         cur_r <= cur_nxt;
         last_r <= last_nxt;
      end
   end

   // array cells, one word per step, masked by byte lane
   always_ff @(posedge clk)
   begin
      if (do_wr && wmask[1])
         mem[cur_r][15:8] <= wval[15:8];
      if (do_wr && wmask[0])
         mem[cur_r][7:0] <= wval[7:0];
   end

   // ****************************************
   // program latches
   // ****************************************
   // first array write of an operation wins, so a misaligned word
   // pair keeps only its lower byte
   wire arr_wr = wr & in_arr & lat & ~pgm & ~lat_valid_r;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lat_idx_r <= 9'h000;
         lat_dat_r <= 16'h0000;
         lat_sel_r <= 2'b00;
         lat_valid_r <= 1'b0;
      end
      else if (arr_wr)
      begin
         lat_idx_r <= arr_idx;
         lat_dat_r <= wb_dat_i;
         lat_sel_r <= wb_sel_i;
         lat_valid_r <= 1'b1;
      end
      else if (!lat || pgm)
         lat_valid_r <= 1'b0; // rearm for the next location
   end

   // ****************************************
   // control registers
   // ****************************************
   // lock once in normal mode, anytime in special mode
   wire lock_ok = ~special_mode_n | ~lock_used_r;
   wire [7:0] mc_nxt = {5'h00, wd_hi[EECP_MC_RC],
      lock_ok ? wd_hi[EECP_MC_LOCK] : lock, wd_hi[EECP_MC_WCH]};
   // program bit needs the latch bit already set
   wire pgm_nxt = wd_lo[EECP_PC_PGM] & lat;
   wire bulk_erase_protect_nxt = lock ? bulk_erase_protect : wd_lo[EECP_PC_BULK_ERASE_PROTECT];
   wire [7:0] pc_nxt = pgm ? {pctl_r[7:1], wd_lo[EECP_PC_PGM]} :
      {bulk_erase_protect_nxt, 2'b00, wd_lo[4:1], pgm_nxt};

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mcfg_r <= EECP_MCFG_RST;
         lock_used_r <= 1'b0;
         bprot_r <= EECP_BPROT_RST;
         pctl_r <= EECP_PCTL_RST;
         ree_r <= EECP_REE_RST;
      end
      else
      begin
         if (wr_mc)
         begin
            mcfg_r <= mc_nxt;
            lock_used_r <= 1'b1;
         end
         if (wr_bp && !pgm && !lock)
            bprot_r <= wd_lo[4:0];
         if (wr_pc)
            pctl_r <= pc_nxt;
         if (wr_in)
            ree_r <= wd_hi[EECP_IN_REE];
      end
   end

   // test register, cleared whenever not in special mode
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         test_r <= EECP_TEST_RST;
      else if (special_mode_n)
         test_r <= 8'h00;
      else if (wr_ts)
         test_r <= wd_hi & 8'h6F;
   end

   // ****************************************
   // read path and acknowledge
   // ****************************************
   wire arr_rd_ok = in_arr & ree_r & ~lat;
   wire [15:0] rd_val = arr_rd_ok ? mem[arr_idx] :
      hit_mc ? {mcfg_r, 3'h0, bprot_r} :
      hit_ts ? {test_r, pctl_r} :
      hit_in ? {7'h00, ree_r, 8'h00} : 16'h0000;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ack_r <= 1'b0;
         dat_r <= 16'h0000;
      end
      else
      begin
         ack_r <= req;
         if (rd)
            dat_r <= rd_val;
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   lock_once_a: assert property (special_mode_n && lock_used_r
      |=> mcfg_r[EECP_MC_LOCK] == $past(mcfg_r[EECP_MC_LOCK]))
      else $error("lock changed after its one write");
   bprot_held_a: assert property ((pgm || lock) |=> $stable(bprot_r))
      else $error("block protect changed while held");
   test_zero_a: assert property (special_mode_n |=> test_r == 8'h00)
      else $error("test bits live in normal mode");
   pgm_after_lat_a: assert property ($rose(pgm) |-> $past(lat))
      else $error("program bit set without latch bit");
   stop_pump_a: assert property (stop_mode |-> !pump_on && !rc_osc_en)
      else $error("pump or rc clock alive in stop");
   stop_resume_a: assert property (pgm && $fell(stop_mode) && !wait_mode
      && !test_r[EECP_TS_PDIS] |-> pump_on)
      else $error("pump not restored after stop");
   wait_halt_a: assert property (wait_mode && wch |-> !module_clk_en)
      else $error("module clocked in wait with halt set");
   wait_run_a: assert property (wait_mode && !wch |-> module_clk_en)
      else $error("wait stopped module with halt clear");
   rc_off_a: assert property (!rc_sel |-> !rc_osc_en)
      else $error("rc clock running with system select");
   pump_dis_a: assert property (test_r[EECP_TS_PDIS] |-> !pump_on)
      else $error("pump on while disabled");
   rd_gate_a: assert property (rd && in_arr && (!ree_r || lat)
      |=> wb_dat_o == 16'h0000)
      else $error("array read leaked while gated");
   prot_skip_a: assert property (step && cur_prot
      |=> mem[$past(cur_r)] == $past(mem[cur_r]))
      else $error("protected word written");
   lat_first_a: assert property (lat_valid_r && !pgm
      |=> $stable(lat_idx_r))
      else $error("program latch overwritten");
   bulk_erase_protect_lock_a: assert property (lock |=> bulk_erase_protect == $past(bulk_erase_protect))
      else $error("bulk protect changed while locked");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   bulk_run_c: cover property (st_r == EECP_RUN && bulk_op);
   row_run_c: cover property (st_r == EECP_RUN && row_op);
   stop_mid_c: cover property (st_r == EECP_RUN && stop_mode);
   done_c: cover property ($rose(st_r == EECP_DONE));
endmodule : eecp_ctrl
`default_nettype wire

// ===== verif/eecp_core_model.sv
// Purpose: processor-side bus master of the eeprom control block
// Assumes: classic wishbone, one single cycle at a time
// Notes: address and data are inverted between cycles
`timescale 1ns/1ns
`default_nettype none
module eecp_core_model
   import eecp_pkg::*;
(
   input wire logic clk,
   input wire logic wb_ack_o,
   input wire logic [15:0] wb_dat_o,
   output logic wb_cyc_i,
   output logic wb_stb_i,
   output logic wb_we_i,
   output logic [15:0] wb_adr_i,
   output logic [1:0] wb_sel_i,
   output logic [15:0] wb_dat_i,
   output logic miss_r
);
   // ****************************************
   // bus cycles
   // ****************************************
   // idle bus at time zero
   initial
   begin
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 34'h0;
   end
   // flag an ack that answers no request or outlives its cycle
   always @(posedge clk)
   begin
      miss_r <= miss_r === 1'b1 || (wb_ack_o === 1'b1 && wb_cyc_i !== 1'b1);
   end
   // hold the request until ack is sampled, then release it
   task automatic xfer(input logic we, input logic [15:0] a,
      input logic [1:0] s, input logic [15:0] d, output logic [15:0] q);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
      do
      begin
         @(posedge clk);
      end
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      {wb_adr_i, wb_dat_i} <= {~a, ~d};
      @(posedge clk);
   endtask : xfer
   // latch, target write, voltage on, hold, then clear
   task automatic prog(input logic [7:0] c, input logic [15:0] a,
      input logic [1:0] s, input logic [15:0] d);
      logic [15:0] q;
      xfer(1'b1, EECP_PCTL_ADR, 2'b01, {8'h00, c | 8'h02}, q);
      xfer(1'b1, a, s, d, q);
      xfer(1'b1, EECP_PCTL_ADR, 2'b01, {8'h00, c | 8'h03}, q);
      repeat (400) @(posedge clk);
      xfer(1'b1, EECP_PCTL_ADR, 2'b01, 16'h0002, q);
      xfer(1'b1, EECP_PCTL_ADR, 2'b01, 16'h0000, q);
   endtask : prog
endmodule : eecp_core_model
`default_nettype wire

// ===== verif/eecp_ctrl_tb_top.sv
// Purpose: self-checking bench of the eeprom control block
// Assumes: normal mode unless a case says otherwise
// Notes: table rows first, then the awkward cases
`timescale 1ns/1ns
`default_nettype none
module eecp_ctrl_tb_top
   import eecp_pkg::*;
;
   typedef struct packed
   {
      logic we;
      logic [15:0] a;
      logic [1:0] s;
      logic [15:0] d;
      logic [15:0] x;
   } eecp_row_s;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic special_mode_n = 1'b1;
   logic wait_mode = 1'b0;
   logic stop_mode = 1'b0;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, miss_r;
   logic [15:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
   logic [1:0] wb_sel_i;
   logic pump_on, pump_clk_sel, rc_osc_en, module_clk_en;
   logic margin_test, pump_ramp_en, pump_monitor_out;
   logic program_voltage_apply;
   logic [7:0] pwr;
   int err_total = 0;
   int num_checks = 0;
   int i;
   logic [15:0] blk [5] = '{EECP_BLK0_LO, EECP_BLK1_LO, EECP_BLK2_LO,
      EECP_BLK3_LO, EECP_ARR_LO};
   eecp_row_s rows [11] = '{
      '{1'b0, 16'h00F0, 2'b11, 16'h0000, 16'h001F},
      '{1'b0, 16'h00F2, 2'b11, 16'h0000, 16'h0000},
      '{1'b0, 16'h0012, 2'b11, 16'h0000, 16'h0100},
      '{1'b1, 16'h00F2, 2'b10, 16'h6F00, 16'h0000},
      '{1'b1, 16'h00F0, 2'b10, 16'h0400, 16'h041F}, // rc pump
      '{1'b1, 16'h00F1, 2'b01, 16'h0000, 16'h0400},
      '{1'b1, 16'h0100, 2'b11, 16'hFFFF, 16'h0000},
      '{1'b1, 16'h00F3, 2'b01, 16'h0003, 16'h0002},
      '{1'b1, 16'h00F3, 2'b01, 16'h0003, 16'h0003},
      '{1'b1, 16'h00F1, 2'b01, 16'h001F, 16'h0400},
      '{1'b1, 16'h00F3, 2'b01, 16'h0002, 16'h0002}};
   // design outputs gathered for one compare
   assign pwr = {program_voltage_apply, pump_on, rc_osc_en, pump_clk_sel,
      module_clk_en, margin_test, pump_ramp_en, pump_monitor_out};
   // 10 MHz clock
   always #50 clk = ~clk;
   eecp_ctrl uut (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .special_mode_n,
      .wait_mode, .stop_mode, .pump_on, .pump_clk_sel, .rc_osc_en,
      .module_clk_en, .margin_test, .pump_ramp_en, .pump_monitor_out,
      .program_voltage_apply);
   eecp_core_model core (.clk, .wb_ack_o, .wb_dat_o, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .miss_r);
   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [15:0] a, input logic [1:0] s,
      input logic [15:0] d);
      logic [15:0] r;
      core.xfer(1'b1, a, s, d, r);
   endtask : wr
   task automatic rc(input logic [15:0] a, input logic [15:0] x);
      logic [15:0] r;
      core.xfer(1'b0, a & 16'hFFFE, 2'b11, 16'h0000, r);
      check(r, x);
   endtask : rc
   task automatic pc(input logic [7:0] x, input logic [7:0] m);
      @(negedge clk);
      check({8'h00, pwr & m}, {8'h00, x & m});
      @(posedge clk);
   endtask : pc
   task automatic rst();
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
   endtask : rst
   task automatic summarize();
      if (miss_r !== 1'b0)
         err_total++;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   // watchdog against a hung handshake
   initial
   begin
      #2000000;
      err_total++;
      summarize();
   end
   // main sequence
   initial
   begin
      rst();
      foreach (rows[k])
      begin
         if (rows[k].we)
            wr(rows[k].a, rows[k].s, rows[k].d);
         rc(rows[k].a, rows[k].x);
      end
      // voltage, stop and wait around a set program bit with no word latched
      wr(EECP_PCTL_ADR, 2'b01, 16'h0003);
      pc(8'hFA, 8'hFF);
      stop_mode <= 1'b1;
      pc(8'h98, 8'hFF);
      stop_mode <= 1'b0;
      pc(8'hFA, 8'hFF);
      wait_mode <= 1'b1;
      pc(8'hFA, 8'hFF);
      wr(EECP_MCFG_ADR, 2'b10, 16'h0500);
      pc(8'h00, 8'h08);
      wait_mode <= 1'b0;
      pc(8'hFA, 8'hFF);
      wr(EECP_PCTL_ADR, 2'b01, 16'h0002);
      wr(EECP_PCTL_ADR, 2'b01, 16'h0000);
      wr(EECP_MCFG_ADR, 2'b10, 16'h0400);
      // erase granularity and read widths
      core.prog(8'h04, EECP_ARR_LO, 2'b11, 16'h0000);
      rc(EECP_ARR_HI, 16'hFFFF);
      core.prog(8'h00, 16'h0D10, 2'b11, 16'hA55A);
      rc(16'h0D10, 16'hA55A);
      core.xfer(1'b0, 16'h0D11, 2'b01, 16'h0000, q);
      check({8'h00, q[7:0]}, 16'h005A);
      core.prog(8'h00, 16'h0D21, 2'b01, 16'h0033);
      core.prog(8'h0C, 16'h0D10, 2'b11, 16'h0000);
      rc(16'h0D10, 16'hFFFF);
      rc(16'h0D20, 16'hFF33);
      core.prog(8'h14, 16'h0D21, 2'b01, 16'h0000);
      rc(16'h0D20, 16'hFFFF);
      // misaligned word: two byte cycles, only the first is latched
      wr(EECP_PCTL_ADR, 2'b01, 16'h0002);
      wr(16'h0D31, 2'b01, 16'h00AB);
      wr(16'h0D32, 2'b10, 16'hCD00);
      wr(EECP_PCTL_ADR, 2'b01, 16'h0003);
      repeat (8) @(posedge clk);
      wr(EECP_PCTL_ADR, 2'b01, 16'h0002);
      wr(EECP_PCTL_ADR, 2'b01, 16'h0000);
      rc(16'h0D30, 16'hFFAB);
      rc(16'h0D32, 16'hFFFF);
      // each protect bit against its own block
      for (i = 0; i < 5; i++)
      begin
         wr(EECP_BPROT_ADR, 2'b01, 16'h0001 << i);
         core.prog(8'h00, blk[i], 2'b11, 16'h5A00 + 16'(i));
         rc(blk[i], 16'hFFFF);
         wr(EECP_BPROT_ADR, 2'b01, 16'h001F ^ (16'h0001 << i));
         core.prog(8'h00, blk[i], 2'b11, 16'h5A00 + 16'(i));
         rc(blk[i], 16'h5A00 + 16'(i));
      end
      // array read gate leaves registers and programming alone
      wr(EECP_BPROT_ADR, 2'b01, 16'h0000);
      wr(EECP_INIT_ADR, 2'b10, 16'h0000);
      rc(EECP_BLK0_LO, 16'h0000);
      rc(EECP_MCFG_ADR, 16'h0400);
      core.prog(8'h00, 16'h0E02, 2'b11, 16'h1234);
      wr(EECP_INIT_ADR, 2'b10, 16'h0100);
      rc(16'h0E02, 16'h1234);
      // protect lock in normal and special mode
      rst();
      wr(EECP_MCFG_ADR, 2'b10, 16'h0200);
      wr(EECP_BPROT_ADR, 2'b01, 16'h0000);
      wr(EECP_MCFG_ADR, 2'b10, 16'h0000);
      rc(EECP_MCFG_ADR, 16'h021F);
      wr(EECP_PCTL_ADR, 2'b01, 16'h0080);
      rc(EECP_TEST_ADR, 16'h0000);
      rst();
      rc(EECP_MCFG_ADR, 16'h001F);
      special_mode_n <= 1'b0;
      wr(EECP_MCFG_ADR, 2'b10, 16'h0200);
      wr(EECP_MCFG_ADR, 2'b10, 16'h0000);
      wr(EECP_PCTL_ADR, 2'b01, 16'h0080);
      rc(EECP_MCFG_ADR, 16'h001F);
      // test controls in special mode
      wr(EECP_TEST_ADR, 2'b10, 16'h6F00);
      rc(EECP_TEST_ADR, 16'h6F80);
      wr(EECP_PCTL_ADR, 2'b01, 16'h0002);
      wr(EECP_PCTL_ADR, 2'b01, 16'h0003);
      pc(8'h8D, 8'hFF);
      wr(EECP_TEST_ADR, 2'b10, 16'h0800);
      pc(8'hCE, 8'hFF);
      wr(EECP_TEST_ADR, 2'b10, 16'h0A00);
      pc(8'hCC, 8'hFF);
      // odd-row bulk erase in special mode spares the even rows
      wr(EECP_PCTL_ADR, 2'b01, 16'h0002);
      wr(EECP_BPROT_ADR, 2'b01, 16'h0000);
      wr(EECP_TEST_ADR, 2'b10, 16'h4000);
      core.prog(8'h04, 16'h0D30, 2'b11, 16'h0000);
      rc(16'h0D30, 16'hFFFF);
      rc(16'h0D00, 16'h5A04);
      summarize();
   end
endmodule : eecp_ctrl_tb_top
`default_nettype wire
